// ### hdl/phy_irq_pkg.sv
// Constants and types for the interrupt control and status register and its management frames
package phy_irq_pkg;

  // One bit per event, in register order: jabber in the top bit, link up in the bottom
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_rx;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } irq_bits_s;

  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_START,
    ST_HEADER,
    ST_TA1,
    ST_TA2,
    ST_DATA
  } mdio_state_e;

  localparam logic [4:0]  REG_IRQ_CTRL_STAT = 5'h1B;
  localparam logic [4:0]  PHY_ADDR_DEFAULT  = 5'h01;
  localparam logic [1:0]  OP_READ           = 2'h2;
  localparam logic [1:0]  OP_WRITE          = 2'h1;
  localparam logic [5:0]  PREAMBLE_BITS     = 6'h20;
  localparam logic [3:0]  HEADER_BITS       = 4'hC;
  localparam logic [4:0]  DATA_LAST         = 5'h0F;
  localparam logic [15:0] UNMAPPED_READ     = 16'h0000;

  localparam int          ENABLE_LSB        = 8;
  localparam int          ENABLE_MSB        = 15;
  localparam int          STATUS_LSB        = 0;
  localparam int          STATUS_MSB        = 7;
  localparam irq_bits_s   ENABLE_RST        = 8'h00;
  localparam irq_bits_s   STATUS_RST        = 8'h00;
  localparam logic        MDC_IDLE          = 1'b0;
  localparam logic        MDIO_IDLE         = 1'b1;

endpackage : phy_irq_pkg

// ### hdl/pin_sync.sv
// Three-stage pin synchroniser with a two-sample agreement filter
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys_in,   // System clock
  input  wire logic reset_in,     // Asynchronous reset, active high
  input  wire logic pin_in,       // Raw pin level
  output logic      level_out     // Filtered level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic agree;

  // Only the second and third stages are compared; the first may be metastable
  assign agree     = (s2_ff == s3_ff);
  assign level_out = level_ff;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      s1_ff    <= RST_VAL;
      s2_ff    <= RST_VAL;
      s3_ff    <= RST_VAL;
      level_ff <= RST_VAL;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        level_ff <= s3_ff;
      end
    end
  end

endmodule : pin_sync

// ### hdl/phy_interrupt_ctrl_status.sv
// Interrupt control and status register reached over the serial management frames
`timescale 1ns/100ps
module phy_interrupt_ctrl_status
  import phy_irq_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
) (
  input  wire logic       clk_sys_in,     // System clock, 40 MHz
  input  wire logic       reset_in,       // Asynchronous reset, active high
  input  wire irq_bits_s  event_in,       // One-cycle event pulses from the link logic
  input  wire logic       mdc_in,         // Management clock pin
  input  wire logic       mdio_in,        // Management data pin, input side
  output logic            mdio_out,       // Management data pin, output value
  output logic            mdio_oe_n_out,  // Management data drive enable, low while driving
  output logic            intr_out,       // Interrupt indication, active high
  output irq_bits_s       enable_out,     // Current enable bits
  output irq_bits_s       status_out      // Current latched status bits
);

  // Each MDC phase must span at least two system clocks; the sampler and its
  // agreement filter would miss a shorter one, so a fast management clock needs care.

  function automatic logic set_wins(input logic held, input logic ev, input logic clr);
    set_wins = (held & ~clr) | ev;
  endfunction : set_wins

  logic         mdc_s;
  logic         mdio_s;
  logic         mdc_prev_ff;
  mdio_state_e  state_ff;
  mdio_state_e  nxt_state;
  logic [5:0]   cnt_ff;
  logic [5:0]   nxt_cnt;
  logic [11:0]  hdr_ff;
  logic [11:0]  nxt_hdr;
  logic [15:0]  shift_ff;
  logic [15:0]  nxt_shift;
  logic         is_read_ff;
  logic         nxt_is_read;
  logic         is_write_ff;
  logic         nxt_is_write;
  logic         drive_ff;
  logic         nxt_drive;
  logic         dout_ff;
  logic         nxt_dout;
  irq_bits_s    enable_ff;
  irq_bits_s    nxt_enable;
  irq_bits_s    status_ff;
  irq_bits_s    nxt_status;
  logic         intr_ff;

  wire logic        mdc_rise;
  wire logic [11:0] hdr_full;
  wire logic [1:0]  hdr_op;
  wire logic [4:0]  hdr_phy;
  wire logic [4:0]  hdr_reg;
  wire logic        phy_hit;
  wire logic        reg_hit;
  wire logic [15:0] reg_image;
  wire logic [15:0] read_word;
  wire logic        read_clear;
  wire logic        write_commit;
  wire logic [15:0] write_word;
  wire irq_bits_s   pending;

  pin_sync #(.RST_VAL(MDC_IDLE)) u_mdc_sync (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     (mdc_in),
    .level_out  (mdc_s)
  );

  pin_sync #(.RST_VAL(MDIO_IDLE)) u_mdio_sync (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     (mdio_in),
    .level_out  (mdio_s)
  );

  assign mdc_rise  = mdc_s & ~mdc_prev_ff;
  assign hdr_full  = {hdr_ff[10:0], mdio_s};
  // Op and PHY address are decoded from the word as the last header bit arrives; register address from the stored header
  assign hdr_op    = hdr_full[11:10];
  assign hdr_phy   = hdr_full[9:5];
  assign hdr_reg   = hdr_ff[4:0];
  assign phy_hit   = (hdr_phy == PHY_ADDR);
  assign reg_hit   = (hdr_reg == REG_IRQ_CTRL_STAT);
  assign reg_image = {enable_ff, status_ff};
  assign read_word = reg_hit ? reg_image : UNMAPPED_READ;

  // Snapshot and clear happen on the same edge, so nothing latched after it is lost
  assign read_clear   = mdc_rise & (state_ff == ST_TA1) & is_read_ff & reg_hit;
  assign write_word   = {shift_ff[14:0], mdio_s};
  assign write_commit = mdc_rise & (state_ff == ST_DATA) & (cnt_ff[4:0] == DATA_LAST) & is_write_ff & reg_hit;

  // Frame engine: preamble, start, op/phy/reg header, turnaround, sixteen data bits
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_hdr      = hdr_ff;
    nxt_shift    = shift_ff;
    nxt_is_read  = is_read_ff;
    nxt_is_write = is_write_ff;
    nxt_drive    = drive_ff;
    nxt_dout     = dout_ff;
    if (mdc_rise) begin
      case (state_ff)
        ST_PREAMBLE: begin
          if (mdio_s) begin
            if (cnt_ff != PREAMBLE_BITS) begin
              nxt_cnt = cnt_ff + 6'h01;
            end
          end else if (cnt_ff == PREAMBLE_BITS) begin
            nxt_state = ST_START;
            nxt_cnt   = 6'h00;
          end else begin
            nxt_cnt = 6'h00;
          end
        end
        ST_START: begin
          nxt_cnt   = 6'h00;
          nxt_state = mdio_s ? ST_HEADER : ST_PREAMBLE;
        end
        ST_HEADER: begin
          nxt_hdr = hdr_full;
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff[3:0] == HEADER_BITS - 4'h1) begin
            nxt_state    = ST_TA1;
            nxt_cnt      = 6'h00;
            nxt_is_read  = (hdr_op == OP_READ) & phy_hit;
            nxt_is_write = (hdr_op == OP_WRITE) & phy_hit;
          end
        end
        ST_TA1: begin
          nxt_state = ST_TA2;
          if (is_read_ff) begin
            nxt_shift = read_word;
            nxt_drive = 1'b1;
            nxt_dout  = 1'b0;
          end
        end
        ST_TA2: begin
          nxt_state = ST_DATA;
          nxt_cnt   = 6'h00;
          if (is_read_ff) begin
            nxt_dout  = shift_ff[15];
            nxt_shift = {shift_ff[14:0], 1'b0};
          end
        end
        ST_DATA: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (is_read_ff) begin
            nxt_dout  = shift_ff[15];
            nxt_shift = {shift_ff[14:0], 1'b0};
          end else begin
            nxt_shift = write_word;
          end
          if (cnt_ff[4:0] == DATA_LAST) begin
            nxt_state    = ST_PREAMBLE;
            nxt_cnt      = 6'h00;
            nxt_drive    = 1'b0;
            nxt_dout     = MDIO_IDLE;
            nxt_is_read  = 1'b0;
            nxt_is_write = 1'b0;
          end
        end
        default: begin
          nxt_state = ST_PREAMBLE;
          nxt_cnt   = 6'h00;
          nxt_drive = 1'b0;
        end
      endcase
    end
  end

  // Enables take the upper byte of a write; status bits ignore writes
  always_comb begin
    nxt_enable = enable_ff;
    if (write_commit) begin
      nxt_enable = irq_bits_s'(write_word[ENABLE_MSB:ENABLE_LSB]);
    end
  end

  // A new event in the clearing cycle survives for the next read
  always_comb begin
    nxt_status              = status_ff;
    nxt_status.jabber       = set_wins(status_ff.jabber,       event_in.jabber,       read_clear);
    nxt_status.rx_error     = set_wins(status_ff.rx_error,     event_in.rx_error,     read_clear);
    nxt_status.page_rx      = set_wins(status_ff.page_rx,      event_in.page_rx,      read_clear);
    nxt_status.pd_fault     = set_wins(status_ff.pd_fault,     event_in.pd_fault,     read_clear);
    nxt_status.lp_ack       = set_wins(status_ff.lp_ack,       event_in.lp_ack,       read_clear);
    nxt_status.link_down    = set_wins(status_ff.link_down,    event_in.link_down,    read_clear);
    nxt_status.remote_fault = set_wins(status_ff.remote_fault, event_in.remote_fault, read_clear);
    nxt_status.link_up      = set_wins(status_ff.link_up,      event_in.link_up,      read_clear);
  end

  // Every enable gates its own status bit onto the one indication
  assign pending = status_ff & enable_ff;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      mdc_prev_ff <= MDC_IDLE;
      state_ff    <= ST_PREAMBLE;
      cnt_ff      <= 6'h00;
      hdr_ff      <= 12'h000;
      shift_ff    <= 16'h0000;
      is_read_ff  <= 1'b0;
      is_write_ff <= 1'b0;
      drive_ff    <= 1'b0;
      dout_ff     <= MDIO_IDLE;
    end else begin
      mdc_prev_ff <= mdc_s;
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      hdr_ff      <= nxt_hdr;
      shift_ff    <= nxt_shift;
      is_read_ff  <= nxt_is_read;
      is_write_ff <= nxt_is_write;
      drive_ff    <= nxt_drive;
      dout_ff     <= nxt_dout;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      enable_ff <= ENABLE_RST;
      status_ff <= STATUS_RST;
      intr_ff   <= 1'b0;
    end else begin
      enable_ff <= nxt_enable;
      status_ff <= nxt_status;
      intr_ff   <= |pending;
    end
  end

  assign mdio_out      = dout_ff;
  assign mdio_oe_n_out = ~drive_ff;
  assign intr_out      = intr_ff;
  assign enable_out    = enable_ff;
  assign status_out    = status_ff;

endmodule : phy_interrupt_ctrl_status

// ### verif/phy_irq_monitor.sv
// Port checker for the interrupt control and status block
`timescale 1ns/100ps
module phy_irq_monitor import phy_irq_pkg::*; (
  input wire logic      clk_sys_in,    // Clock
  input wire logic      reset_in,      // Reset
  input wire irq_bits_s event_in,      // Events
  input wire logic      mdc_in,        // MDC pin
  input wire logic      mdio_in,       // Data in
  input wire logic      mdio_out,      // Data out
  input wire logic      mdio_oe_n_out, // Drive enable
  input wire logic      intr_out,      // Interrupt
  input wire irq_bits_s enable_out,    // Enables
  input wire irq_bits_s status_out     // Status
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic [8:0] low_cnt_ff;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) low_cnt_ff <= 9'h000;
    else low_cnt_ff <= mdio_oe_n_out ? 9'h000 : low_cnt_ff + 9'h001;
  end
  chk_event_sets_bit:
    assert property (|event_in |=> (status_out & $past(event_in)) == $past(event_in)) else $error("event lost");
  chk_no_spurious_set:
    assert property ((status_out & ~$past(status_out) & ~$past(event_in)) == 8'h00) else $error("bit set alone");
  chk_intr_enabled_or:
    assert property (intr_out == |($past(status_out) & $past(enable_out))) else $error("interrupt wrong");
  chk_clear_on_read:
    assert property ((($past(status_out) & ~status_out) != 8'h00) |-> ##[0:3] !mdio_oe_n_out)
      else $error("status cleared outside read");
  chk_enable_read_stable:
    assert property (!mdio_oe_n_out |-> $stable(enable_out)) else $error("enable moved in read");
  chk_turnaround_zero:
    assert property ($fell(mdio_oe_n_out) |-> ##1 !mdio_out [*6]) else $error("turnaround not zero");
  chk_idle_high:
    assert property (mdio_oe_n_out [*3] |-> mdio_out) else $error("idle data low");
  chk_drive_length:
    assert property ($rose(mdio_oe_n_out) |-> low_cnt_ff inside {[9'h0C6:9'h0D2]}) else $error("drive length off");
  cov_intr: cover property ($rose(intr_out));
  cov_read: cover property ($fell(mdio_oe_n_out));
  cov_enable: cover property ($changed(enable_out));
  cov_zero_bit: cover property ($rose(mdc_in) && !mdio_in);
endmodule : phy_irq_monitor
bind phy_interrupt_ctrl_status phy_irq_monitor phy_irq_monitor_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .event_in(event_in), .mdc_in(mdc_in), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n_out(mdio_oe_n_out),
  .intr_out(intr_out), .enable_out(enable_out), .status_out(status_out));

// ### verif/mgmt_station_model.sv
// Station management controller model that issues management frames
`timescale 1ns/100ps
module mgmt_station_model import phy_irq_pkg::*; #(
  parameter int HALF = 6  // Sys clocks per MDC phase; the pin sampler needs two
) (
  input  wire logic clk_sys_in,  // Clock
  input  wire logic mdio_in,     // Resolved wire
  output logic      mdc_out,     // MDC, still between frames
  output logic      mdio_out,    // Driven value
  output logic      mdio_en_out  // Station drives
);
  initial begin
    mdc_out = MDC_IDLE;
    mdio_out = 1'b1;
    mdio_en_out = 1'b0;
  end
  task automatic bit_cycle(input logic drv, input logic val, output logic smp);
    mdio_en_out = drv;
    mdio_out = val;
    repeat (HALF) @(posedge clk_sys_in);
    #1 mdc_out = 1'b1;
    smp = mdio_in;
    repeat (HALF) @(posedge clk_sys_in);
    #1 mdc_out = 1'b0;
  endtask : bit_cycle
  // Full preamble on every frame, station lets go of the wire over turnaround on reads
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, op, phy, reg_a};
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    bit_cycle(op == OP_WRITE, 1'b1, s);
    bit_cycle(op == OP_WRITE, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(op == OP_WRITE, wd[i], s);
      rd[i] = s;
    end
    mdio_en_out = 1'b0;
  endtask : frame
endmodule : mgmt_station_model

// ### verif/phy_interrupt_ctrl_status_tb_top.sv
// Self-checking bench for the interrupt control and status block
`timescale 1ns/100ps
module phy_interrupt_ctrl_status_tb_top import phy_irq_pkg::*;;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, mdc, st_do, st_en, mdio_out, mdio_oe_n_out, intr_out;
  irq_bits_s event_in = STATUS_RST, enable_out, status_out;
  int n_fail = 0, samples_checked = 0, cycles = 0, en_m = 0, st_m = 0;
  integer seed;
  logic [15:0] w, d;
  // Pull-up on the data wire when nobody drives it
  wire mdio_wire = !mdio_oe_n_out ? mdio_out : (st_en ? st_do : 1'b1);
  always #12.5 clk_sys_in = ~clk_sys_in;
  phy_interrupt_ctrl_status #(.PHY_ADDR(PHY_ADDR_DEFAULT)) phy_interrupt_ctrl_status_i (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .event_in(event_in), .mdc_in(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe_n_out(mdio_oe_n_out), .intr_out(intr_out), .enable_out(enable_out), .status_out(status_out));
  mgmt_station_model mgmt_station_model_i (.clk_sys_in(clk_sys_in), .mdio_in(mdio_wire), .mdc_out(mdc),
    .mdio_out(st_do), .mdio_en_out(st_en));
  task automatic close_out();
    $display("compared %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step
  task automatic flags();
    check({enable_out, status_out}, 16'(((en_m & 8'hFF) << 8) | st_m), "flags");
    check(16'(intr_out), 16'((en_m & st_m) != 0), "intr");
  endtask : flags
  task automatic pulse(input irq_bits_s ev);
    event_in = ev;
    step(1);
    event_in = STATUS_RST;
    st_m = st_m | int'(ev);
    step(2);
    flags();
  endtask : pulse
  task automatic rd(input logic [4:0] reg_a, input logic [4:0] phy);
    mgmt_station_model_i.frame(OP_READ, phy, reg_a, 16'h0000, d);
    if (phy != PHY_ADDR_DEFAULT) check(d, 16'hFFFF, "foreign read");
    else if (reg_a != REG_IRQ_CTRL_STAT) check(d, UNMAPPED_READ, "unmapped read");
    else check(d, 16'(((en_m & 8'hFF) << 8) | st_m), "read");
    if (phy == PHY_ADDR_DEFAULT && reg_a == REG_IRQ_CTRL_STAT) st_m = 0;
    step(4);
    flags();
  endtask : rd
  task automatic wr(input logic [4:0] reg_a, input logic [15:0] wd);
    mgmt_station_model_i.frame(OP_WRITE, PHY_ADDR_DEFAULT, reg_a, wd, d);
    if (reg_a == REG_IRQ_CTRL_STAT) en_m = int'(wd[15:8]);
    step(4);
    flags();
  endtask : wr
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      $display("mismatch at %0t: run too long", $time);
      close_out();
    end
  end
  initial begin
    seed = 32'hDE02D978;
    step(8);
    reset_in = 1'b0;
    step(4);
    flags();
    rd(REG_IRQ_CTRL_STAT, PHY_ADDR_DEFAULT);
    for (int k = 0; k < 8; k++) begin
      pulse(irq_bits_s'(8'h01 << k));
      rd(REG_IRQ_CTRL_STAT, PHY_ADDR_DEFAULT);
      rd(REG_IRQ_CTRL_STAT, PHY_ADDR_DEFAULT);
    end
    for (int k = 0; k < 3; k++) begin
      wr(REG_IRQ_CTRL_STAT, 16'(16'h0100 << k) | 16'h00FF);
      pulse(irq_bits_s'(8'h07 ^ (8'h01 << k)));
      pulse(irq_bits_s'(8'h01 << k));
      rd(REG_IRQ_CTRL_STAT, PHY_ADDR_DEFAULT);
    end
    for (int n = 0; n < 6; n++) begin
      wr(REG_IRQ_CTRL_STAT, 16'($random(seed)));
      pulse(irq_bits_s'($random(seed)));
      rd(REG_IRQ_CTRL_STAT, PHY_ADDR_DEFAULT);
    end
    wr(5'h1C, 16'hFFFF);
    pulse(irq_bits_s'(8'hFF));
    rd(5'h1C, PHY_ADDR_DEFAULT);
    rd(REG_IRQ_CTRL_STAT, PHY_ADDR_DEFAULT ^ 5'h1F);
    rd(REG_IRQ_CTRL_STAT, PHY_ADDR_DEFAULT);
    close_out();
  end
endmodule : phy_interrupt_ctrl_status_tb_top
